// file: hdl/dma_seq_arbiter.sv
`timescale 1ns/1ps
module dma_seq_arbiter
	import dma_seq_pkg::*;
#(
	parameter int N = NCH
)
(
	// Contenders
	input wire logic [N-1:0] req,
	input wire logic [N-1:0] high,
	// Winner
	output logic gnt_valid,
	output logic [CHW-1:0] gnt_idx
);
	// High level first, then lowest channel number wins
	always_comb
	begin
		gnt_valid = |req;
		gnt_idx = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i] && !high[i])
			begin
				gnt_idx = CHW'(i);
			end
		end
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i] && high[i])
			begin
				gnt_idx = CHW'(i);
			end
		end
	end
endmodule

// file: hdl/dma_seq_top.sv
`timescale 1ns/1ps
module dma_seq_top
	import dma_seq_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral requests and completion
	input wire logic [NCH-1:0] dma_req,
	output logic [NCH-1:0] dma_done,
	// Data transfer port
	output logic xfer_valid,
	input wire logic xfer_ready,
	output logic xfer_write,
	output logic [2:0] xfer_prot,
	output logic [CHW-1:0] xfer_chan,
	output logic [F_NM1_HI-F_NM1_LO:0] xfer_count,
	output logic [31:0] xfer_wdata,
	input wire logic [31:0] xfer_rdata
);
	state_type state_q;
	logic [31:0] pri_q [NCH];
	logic [31:0] alt_q [NCH];
	logic [NCH-1:0] en_q, hi_q, alt_sel_q, pend_q, auto_q, sg_q, done_sts_q;
	logic [CHW-1:0] chan_q;
	logic [31:0] cfg_q, data_q;
	logic [CNTW-1:0] rem_q, grp_q;
	logic [NCH-1:0] done_q;
	logic gnt_valid;
	logic [CHW-1:0] gnt_idx;
	logic [31:0] cur_cfg, wb_cfg, wmask, rd_d;
	logic [2:0] cur_ct, ct;
	logic wr_fire, rd_ok, wr_ok, wb_end, wb_done, wb_toggle, wb_auto, wb_sg_set, wb_sg_clr;
	logic [NCH-1:0] sw_req, en_clr_w, done_clr, chan_bit, req_in;
	logic [7:0] widx, ridx;

	function automatic logic [CNTW-1:0] group_size(input logic [3:0] rpow);
		group_size = (rpow >= RPOW_MAX) ? GROUP_MAX : CNTW'(CNT_ONE << rpow);
	endfunction

	// Register bus slave
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = !s_axi_rvalid;
	assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
		{8{s_axi_wstrb[0]}}};
	assign widx = (s_axi_awaddr - ((s_axi_awaddr >= A_ALT_BASE) ? A_ALT_BASE : A_PRI_BASE)) >> 2;
	assign ridx = (s_axi_araddr - ((s_axi_araddr >= A_ALT_BASE) ? A_ALT_BASE : A_PRI_BASE)) >> 2;
	assign sw_req = (wr_fire && s_axi_awaddr == A_SW_REQ) ? s_axi_wdata[NCH-1:0] & wmask[NCH-1:0] : '0;
	assign en_clr_w = (wr_fire && s_axi_awaddr == A_EN_CLR) ? s_axi_wdata[NCH-1:0] & wmask[NCH-1:0] : '0;
	assign done_clr = (wr_fire && s_axi_awaddr == A_DONE_STS) ? s_axi_wdata[NCH-1:0] & wmask[NCH-1:0] : '0;

	always_comb
	begin
		wr_ok = 1'b1;
		if (s_axi_awaddr[1:0] != 2'h0)
			wr_ok = 1'b0;
		else if (s_axi_awaddr >= A_PRI_BASE)
			wr_ok = (widx < 8'(NCH));
		else
			wr_ok = (s_axi_awaddr <= A_DONE_STS);
	end

	always_comb
	begin
		rd_ok = 1'b1;
		rd_d = '0;
		if (s_axi_araddr[1:0] != 2'h0)
			rd_ok = 1'b0;
		else if (s_axi_araddr >= A_PRI_BASE)
		begin
			rd_ok = (ridx < 8'(NCH));
			if (rd_ok)
				rd_d = (s_axi_araddr >= A_ALT_BASE) ? alt_q[ridx[CHW-1:0]] : pri_q[ridx[CHW-1:0]];
		end
		else
		begin
			unique case (s_axi_araddr)
				A_EN_SET: rd_d[NCH-1:0] = en_q;
				A_EN_CLR: rd_d[NCH-1:0] = en_q;
				A_SW_REQ: rd_d[NCH-1:0] = pend_q | auto_q;
				A_PRIO_HI: rd_d[NCH-1:0] = hi_q;
				A_ALT_SEL: rd_d[NCH-1:0] = alt_sel_q;
				A_DONE_STS: rd_d[NCH-1:0] = done_sts_q;
				A_STATUS: rd_d[10:0] = {chan_q, sg_q[chan_q], state_q, state_q != ST_IDLE, 2'h0};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_d;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Arbitration over enabled channels only
	dma_seq_arbiter #(.N(NCH)) u_arb (
		.req((pend_q | auto_q) & en_q),
		.high(hi_q),
		.gnt_valid(gnt_valid),
		.gnt_idx(gnt_idx)
	);

	assign cur_cfg = alt_sel_q[chan_q] ? alt_q[chan_q] : pri_q[chan_q];
	assign cur_ct = cur_cfg[F_CT_HI:F_CT_LO];
	assign ct = cfg_q[F_CT_HI:F_CT_LO];
	assign chan_bit = NCH'(1) << chan_q;
	assign req_in = (dma_req | sw_req) & en_q;

	// Cycle end decisions at write-back
	always_comb
	begin
		wb_end = (rem_q == '0);
		wb_done = 1'b0;
		wb_toggle = 1'b0;
		wb_auto = 1'b0;
		wb_sg_set = 1'b0;
		wb_sg_clr = 1'b0;
		wb_cfg = cfg_q;
		wb_cfg[F_NM1_HI:F_NM1_LO] = 10'(rem_q - CNT_ONE);
		if (wb_end)
			wb_cfg[F_CT_HI:F_CT_LO] = CT_INVALID;
		unique case (ct)
			CT_BASIC:
			begin
				wb_done = wb_end && !sg_q[chan_q];
				wb_sg_clr = wb_end;
			end
			CT_AUTO:
			begin
				wb_done = wb_end;
				wb_auto = !wb_end;
				wb_sg_clr = wb_end;
			end
			CT_PINGPONG:
			begin
				wb_done = wb_end;
				wb_toggle = wb_end;
			end
			CT_MSG_PRI:
			begin
				wb_toggle = 1'b1;
				wb_auto = 1'b1;
				wb_sg_set = 1'b1;
			end
			CT_MSG_ALT:
			begin
				wb_toggle = wb_end;
				wb_auto = 1'b1;
			end
			default:
			begin
				wb_done = 1'b0;
			end
		endcase
	end

	// Sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_IDLE;
			chan_q <= '0;
			cfg_q <= CFG_RESET;
			rem_q <= '0;
			grp_q <= '0;
			data_q <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (gnt_valid)
					begin
						chan_q <= gnt_idx;
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH:
				begin
					cfg_q <= cur_cfg;
					rem_q <= CNTW'(cur_cfg[F_NM1_HI:F_NM1_LO]) + CNT_ONE;
					grp_q <= (group_size(cur_cfg[F_RPOW_HI:F_RPOW_LO]) <
						CNTW'(cur_cfg[F_NM1_HI:F_NM1_LO]) + CNT_ONE) ?
						group_size(cur_cfg[F_RPOW_HI:F_RPOW_LO]) :
						CNTW'(cur_cfg[F_NM1_HI:F_NM1_LO]) + CNT_ONE;
					state_q <= (cur_ct == CT_INVALID || cur_ct == CT_PSG_PRI ||
						cur_ct == CT_PSG_ALT) ? ST_IDLE : ST_READ;
				end
				ST_READ:
				begin
					if (xfer_ready)
					begin
						data_q <= xfer_rdata;
						state_q <= ST_WRITE;
					end
				end
				ST_WRITE:
				begin
					if (xfer_ready)
					begin
						rem_q <= rem_q - CNT_ONE;
						grp_q <= grp_q - CNT_ONE;
						state_q <= (grp_q == CNT_ONE) ? ST_WBACK : ST_READ;
					end
				end
				ST_WBACK:
				begin
					state_q <= ST_IDLE;
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign xfer_valid = (state_q == ST_READ) || (state_q == ST_WRITE);
	assign xfer_write = (state_q == ST_WRITE);
	assign xfer_prot = xfer_write ? cfg_q[F_DPROT_HI:F_DPROT_LO] :
		cfg_q[F_SPROT_HI:F_SPROT_LO];
	assign xfer_chan = chan_q;
	assign xfer_count = 10'(rem_q - CNT_ONE);
	assign xfer_wdata = data_q;

	// Descriptor store; engine updates win over bus writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				pri_q[i] <= CFG_RESET;
				alt_q[i] <= CFG_RESET;
			end
		end
		else
		begin
			if (wr_fire && wr_ok && s_axi_awaddr >= A_ALT_BASE)
				alt_q[widx[CHW-1:0]] <= (alt_q[widx[CHW-1:0]] & ~wmask) | (s_axi_wdata & wmask);
			else if (wr_fire && wr_ok && s_axi_awaddr >= A_PRI_BASE)
				pri_q[widx[CHW-1:0]] <= (pri_q[widx[CHW-1:0]] & ~wmask) | (s_axi_wdata & wmask);
			if (state_q == ST_WRITE && xfer_ready && ct == CT_MSG_PRI && grp_q == CFG_BEAT)
				alt_q[chan_q] <= data_q;
			if (state_q == ST_WBACK)
			begin
				if (alt_sel_q[chan_q])
					alt_q[chan_q] <= wb_cfg;
				else
					pri_q[chan_q] <= wb_cfg;
			end
		end
	end

	// Channel flags; hardware set wins over clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			en_q <= '0;
			hi_q <= '0;
			alt_sel_q <= '0;
			pend_q <= '0;
			auto_q <= '0;
			sg_q <= '0;
		end
		else
		begin
			if (wr_fire && s_axi_awaddr == A_EN_SET)
				en_q <= en_q | (s_axi_wdata[NCH-1:0] & wmask[NCH-1:0]);
			else
				en_q <= en_q & ~en_clr_w;
			if (wr_fire && s_axi_awaddr == A_PRIO_HI)
				hi_q <= s_axi_wdata[NCH-1:0] & wmask[NCH-1:0];
			pend_q <= (pend_q & ~((state_q == ST_FETCH) ? chan_bit : '0)) | req_in;
			auto_q <= (auto_q & ~((state_q == ST_FETCH) ? chan_bit : '0) & en_q) |
				((state_q == ST_WBACK && wb_auto) ? chan_bit : '0);
			if (state_q == ST_FETCH && (cur_ct == CT_INVALID || cur_ct == CT_PSG_PRI ||
				cur_ct == CT_PSG_ALT))
				sg_q <= sg_q & ~chan_bit;
			else if (state_q == ST_WBACK)
				sg_q <= (sg_q & ~(wb_sg_clr ? chan_bit : '0)) | (wb_sg_set ? chan_bit : '0);
			if (state_q == ST_WBACK && wb_toggle)
				alt_sel_q <= alt_sel_q ^ chan_bit;
			else if (wr_fire && s_axi_awaddr == A_ALT_SEL)
				alt_sel_q <= s_axi_wdata[NCH-1:0] & wmask[NCH-1:0];
		end
	end

	// Completion pulse and sticky status
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_q <= '0;
			done_sts_q <= '0;
		end
		else
		begin
			done_q <= (state_q == ST_WBACK && wb_done) ? chan_bit : '0;
			done_sts_q <= (done_sts_q & ~done_clr) | done_q;
		end
	end

	assign dma_done = done_q;

	sequence read_beat_s;
		state_q == ST_READ && xfer_ready;
	endsequence

	sequence write_beat_s;
		state_q == ST_WRITE && xfer_ready;
	endsequence

	done_one_cycle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		|dma_done |=> dma_done == '0) else $error("done pulse too long");
	prot_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
		xfer_valid |-> xfer_prot == (xfer_write ? cfg_q[F_DPROT_HI:F_DPROT_LO] :
		cfg_q[F_SPROT_HI:F_SPROT_LO]))
		else $error("protection from wrong field");
	beat_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
		read_beat_s |=> state_q == ST_WRITE) else $error("read not followed by write");
	group_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		write_beat_s ##0 grp_q == CNT_ONE |=> state_q == ST_WBACK ##1 state_q == ST_IDLE)
		else $error("no re-arbitration after group");
	grant_enabled_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_IDLE && gnt_valid |-> en_q[gnt_idx])
		else $error("disabled channel granted");
	grant_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		gnt_valid && ((pend_q | auto_q) & en_q & hi_q) != '0 |-> hi_q[gnt_idx])
		else $error("default level beat high level");
	invalid_wback_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_WBACK && rem_q == '0 |=> cur_cfg[F_CT_HI:F_CT_LO] == CT_INVALID ||
		alt_sel_q != $past(alt_sel_q))
		else $error("finished descriptor not invalidated");
	sg_switch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_WBACK && ct == CT_MSG_PRI |=> alt_sel_q[chan_q] && auto_q[chan_q])
		else $error("scatter-gather did not switch");
	pend_consumed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state_q == ST_FETCH && !req_in[chan_q] |=> !pend_q[chan_q])
		else $error("request not consumed");
endmodule

// file: pkg/dma_seq_pkg.sv
package dma_seq_pkg;
	localparam int NCH = 12;
	localparam int CHW = 4;
	localparam int CNTW = 11;
	// Cycle type codes
	localparam logic [2:0] CT_INVALID = 3'h0;
	localparam logic [2:0] CT_BASIC = 3'h1;
	localparam logic [2:0] CT_AUTO = 3'h2;
	localparam logic [2:0] CT_PINGPONG = 3'h3;
	localparam logic [2:0] CT_MSG_PRI = 3'h4;
	localparam logic [2:0] CT_MSG_ALT = 3'h5;
	localparam logic [2:0] CT_PSG_PRI = 3'h6;
	localparam logic [2:0] CT_PSG_ALT = 3'h7;
	// Configuration word fields
	localparam int F_DPROT_HI = 23;
	localparam int F_DPROT_LO = 21;
	localparam int F_SPROT_HI = 20;
	localparam int F_SPROT_LO = 18;
	localparam int F_RPOW_HI = 17;
	localparam int F_RPOW_LO = 14;
	localparam int F_NM1_HI = 13;
	localparam int F_NM1_LO = 4;
	localparam int F_CT_HI = 2;
	localparam int F_CT_LO = 0;
	localparam logic [3:0] RPOW_MAX = 4'ha;
	localparam logic [CNTW-1:0] GROUP_MAX = 11'h400;
	localparam logic [CNTW-1:0] CNT_ONE = 11'h001;
	localparam logic [CNTW-1:0] CFG_BEAT = 11'h002;
	// Register byte addresses
	localparam logic [7:0] A_EN_SET = 8'h00;
	localparam logic [7:0] A_EN_CLR = 8'h04;
	localparam logic [7:0] A_SW_REQ = 8'h08;
	localparam logic [7:0] A_PRIO_HI = 8'h0c;
	localparam logic [7:0] A_ALT_SEL = 8'h10;
	localparam logic [7:0] A_DONE_STS = 8'h14;
	localparam logic [7:0] A_STATUS = 8'h18;
	localparam logic [7:0] A_PRI_BASE = 8'h40;
	localparam logic [7:0] A_ALT_BASE = 8'h80;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b011,
		ST_WBACK = 3'b100
	} state_type;
endpackage

// file: tb/tb_dma_cycle_type_sequencer.sv
`timescale 1ns/1ps
module tb_dma_cycle_type_sequencer;
	import dma_seq_pkg::*;
	typedef struct packed {
		logic [3:0] ch;
		logic [2:0] ct;
		logic [3:0] rp;
		logic [9:0] nm1;
		logic [3:0] n;
		logic [3:0] dn;
	} row_type;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awv = 1'b0;
	logic arv = 1'b0;
	logic slow = 1'b0;
	logic seen = 1'b0;
	logic awr, wrr, bv, arr, rv, xv, xr, xw;
	logic [31:0] xwd;
	logic [31:0] last_rd = 32'h0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] cfg_a = 32'h0;
	logic [31:0] cfg_b = 32'h0;
	logic [31:0] rd, rdat, xrd;
	logic [1:0] br, rr;
	logic [NCH-1:0] req = '0;
	logic [NCH-1:0] done, prev;
	logic [2:0] xp;
	logic [2:0] sp = 3'h0;
	logic [2:0] dp = 3'h0;
	logic [CHW-1:0] xc, first;
	logic [9:0] xn;
	row_type rows [7];
	int err_count = 0;
	int n_compared = 0;
	int nwr = 0;
	int ndone = 0;
	always #20 aclk = ~aclk;
	dma_seq_top dut_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awa),
		.s_axi_awvalid(awv),
		.s_axi_awready(awr),
		.s_axi_wdata(wd),
		.s_axi_wstrb(4'hf),
		.s_axi_wvalid(awv),
		.s_axi_wready(wrr),
		.s_axi_bresp(br),
		.s_axi_bvalid(bv),
		.s_axi_bready(1'b1),
		.s_axi_araddr(ara),
		.s_axi_arvalid(arv),
		.s_axi_arready(arr),
		.s_axi_rdata(rdat),
		.s_axi_rresp(rr),
		.s_axi_rvalid(rv),
		.s_axi_rready(1'b1),
		.dma_req(req),
		.dma_done(done),
		.xfer_valid(xv),
		.xfer_ready(xr),
		.xfer_write(xw),
		.xfer_prot(xp),
		.xfer_chan(xc),
		.xfer_count(xn),
		.xfer_wdata(xwd),
		.xfer_rdata(xrd)
	);
	xfer_mem_model mem_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.xfer_valid(xv),
		.xfer_write(xw),
		.xfer_count(xn),
		.xfer_ready(xr),
		.xfer_rdata(xrd),
		.slow(slow),
		.cfg_a(cfg_a),
		.cfg_b(cfg_b)
	);
	task test_done;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task lim(input int i, input int m);
		if (i >= m)
		begin
			err_count++;
			$display("MISMATCH t=%0t wait got=%h exp=%h", $time, i, m);
			test_done;
		end
	endtask
	// Beat monitor: protection per direction, beat and pulse counts
	always @(posedge aclk)
	begin
		prev <= done;
		if (aresetn && xv && xr)
		begin
			chk(32'(xp), 32'(xw ? dp : sp));
			if (xw)
				chk(xwd, last_rd);
			else
				last_rd = xrd;
			nwr = nwr + 32'(xw);
			if (!seen)
				first = xc;
			seen = 1'b1;
		end
		if (aresetn && |done)
		begin
			ndone++;
			chk(32'(done & prev), 32'h0);
		end
	end
	function automatic logic [31:0] mk(input logic [2:0] ct, input logic [3:0] rp,
		input logic [9:0] nm1);
		return {8'haa, dp, sp, rp, nm1, 1'b0, ct};
	endfunction
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		i = 0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		do
		begin
			@(posedge aclk);
			i++;
			lim(i, 100);
		end
		while (awr !== 1'b1 || wrr !== 1'b1);
		awv <= 1'b0;
		do
		begin
			@(posedge aclk);
			i++;
			lim(i, 100);
		end
		while (bv !== 1'b1);
		chk(32'(br), 32'(er));
	endtask
	task axi_rd(input logic [7:0] a, input logic [1:0] er);
		int i;
		i = 0;
		ara <= a;
		arv <= 1'b1;
		do
		begin
			@(posedge aclk);
			i++;
			lim(i, 100);
		end
		while (arr !== 1'b1);
		arv <= 1'b0;
		do
		begin
			@(posedge aclk);
			i++;
			lim(i, 100);
		end
		while (rv !== 1'b1);
		rd = rdat;
		chk(32'(rr), 32'(er));
	endtask
	task settle;
		int i;
		int q;
		i = 0;
		q = 0;
		while (q < 20)
		begin
			@(posedge aclk);
			i++;
			q = (xv === 1'b1) ? 0 : q + 1;
			lim(i, 1000);
		end
	endtask
	task kick(input logic [3:0] c, input logic sw);
		if (sw)
			axi_wr(A_SW_REQ, 32'h1 << c, RESP_OKAY);
		else
		begin
			req[c] <= 1'b1;
			@(posedge aclk);
			req <= '0;
		end
		settle;
	endtask
	task run(input logic [3:0] c, input logic [31:0] cfg);
		nwr = 0;
		ndone = 0;
		axi_wr(A_PRI_BASE + {2'h0, c, 2'h0}, cfg, RESP_OKAY);
		axi_wr(A_EN_SET, 32'h1 << c, RESP_OKAY);
		kick(c, 1'b1);
	endtask
	task prio(input logic [3:0] a, input logic [3:0] b, input logic [11:0] hi,
		input logic [3:0] ex);
		axi_wr(A_PRIO_HI, 32'(hi), RESP_OKAY);
		axi_wr(A_ALT_SEL, 32'h0, RESP_OKAY);
		axi_wr(A_PRI_BASE + {2'h0, a, 2'h0}, mk(CT_AUTO, 4'h0, 10'h1), RESP_OKAY);
		axi_wr(A_PRI_BASE + {2'h0, b, 2'h0}, mk(CT_AUTO, 4'h0, 10'h1), RESP_OKAY);
		axi_wr(A_EN_SET, (32'h1 << a) | (32'h1 << b), RESP_OKAY);
		seen = 1'b0;
		nwr = 0;
		req[a] <= 1'b1;
		req[b] <= 1'b1;
		@(posedge aclk);
		req <= '0;
		settle;
		chk(32'(first), 32'(ex));
		chk(32'(nwr), 32'h4);
	endtask
	initial
	begin
		rows = '{
			'{4'h0, CT_AUTO, 4'h0, 10'h2, 4'h3, 4'h1},
			'{4'h5, CT_AUTO, 4'h1, 10'h4, 4'h5, 4'h1},
			'{4'hb, CT_BASIC, 4'h2, 10'h3, 4'h4, 4'h1},
			'{4'h7, CT_AUTO, 4'hc, 10'h0, 4'h1, 4'h1},
			'{4'h9, CT_INVALID, 4'h0, 10'h1, 4'h0, 4'h0},
			'{4'h9, CT_PSG_PRI, 4'h0, 10'h1, 4'h0, 4'h0},
			'{4'h9, CT_PSG_ALT, 4'h0, 10'h1, 4'h0, 4'h0}};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'(done), 32'h0);
		@(posedge aclk);
		axi_rd(A_PRI_BASE, RESP_OKAY);
		chk(rd, CFG_RESET);
		axi_rd(A_EN_SET, RESP_OKAY);
		chk(rd, 32'h0);
		axi_wr(8'h3c, 32'h1, RESP_SLVERR);
		axi_rd(8'h3c, RESP_SLVERR);
		foreach (rows[k])
		begin
			slow <= k[0];
			sp = 3'(k);
			dp = ~3'(k);
			run(rows[k].ch, mk(rows[k].ct, rows[k].rp, rows[k].nm1));
			chk(32'(nwr), 32'(rows[k].n));
			chk(32'(ndone), 32'(rows[k].dn));
			if (rows[k].dn != 4'h0)
			begin
				axi_rd(A_PRI_BASE + {2'h0, rows[k].ch, 2'h0}, RESP_OKAY);
				chk(32'(rd[2:0]), 32'(CT_INVALID));
			end
		end
		// Basic cycle in three groups of two, two and one
		run(4'h2, mk(CT_BASIC, 4'h1, 10'h4));
		chk(32'(nwr), 32'h2);
		chk(32'(ndone), 32'h0);
		kick(4'h2, 1'b0);
		chk(32'(nwr), 32'h4);
		kick(4'h2, 1'b1);
		chk(32'(nwr), 32'h5);
		chk(32'(ndone), 32'h1);
		// Ping-pong: primary, then alternate, then an invalid primary
		axi_wr(A_ALT_BASE + 8'h0c, mk(CT_PINGPONG, 4'h1, 10'h1), RESP_OKAY);
		run(4'h3, mk(CT_PINGPONG, 4'h0, 10'h0));
		chk(32'(ndone), 32'h1);
		axi_rd(A_ALT_SEL, RESP_OKAY);
		chk(32'(rd[3]), 32'h1);
		kick(4'h3, 1'b0);
		chk(32'(nwr), 32'h3);
		chk(32'(ndone), 32'h2);
		kick(4'h3, 1'b0);
		chk(32'(nwr), 32'h3);
		// Ping-pong ended by a basic final task
		axi_wr(A_ALT_BASE + 8'h0c, mk(CT_BASIC, 4'h0, 10'h0), RESP_OKAY);
		axi_wr(A_PRI_BASE + 8'h0c, mk(CT_PINGPONG, 4'h0, 10'h0), RESP_OKAY);
		kick(4'h3, 1'b0);
		kick(4'h3, 1'b0);
		chk(32'(nwr), 32'h5);
		chk(32'(ndone), 32'h4);
		axi_rd(A_ALT_SEL, RESP_OKAY);
		chk(32'(rd[3]), 32'h1);
		// Memory scatter-gather with two tasks and a slow memory
		slow <= 1'b1;
		cfg_a = mk(CT_MSG_ALT, 4'h0, 10'h1);
		cfg_b = mk(CT_AUTO, 4'h1, 10'h2);
		run(4'ha, mk(CT_MSG_PRI, 4'h2, 10'h7));
		chk(32'(nwr), 32'hd);
		chk(32'(ndone), 32'h1);
		axi_rd(A_PRI_BASE + 8'h28, RESP_OKAY);
		chk(32'(rd[2:0]), 32'(CT_INVALID));
		slow <= 1'b0;
		prio(4'h4, 4'h6, 12'h040, 4'h6);
		prio(4'h1, 4'h2, 12'h000, 4'h1);
		prio(4'ha, 4'hb, 12'h000, 4'ha);
		// Requests on a disabled channel
		nwr = 0;
		axi_wr(A_PRI_BASE + 8'h20, mk(CT_AUTO, 4'h0, 10'h0), RESP_OKAY);
		axi_wr(A_EN_SET, 32'h100, RESP_OKAY);
		axi_wr(A_EN_CLR, 32'h100, RESP_OKAY);
		kick(4'h8, 1'b0);
		chk(32'(nwr), 32'h0);
		test_done;
	end
endmodule

// file: tb/xfer_mem_model.sv
`timescale 1ns/1ps
module xfer_mem_model
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Transfer port
	input wire logic xfer_valid,
	input wire logic xfer_write,
	input wire logic [9:0] xfer_count,
	output logic xfer_ready,
	output logic [31:0] xfer_rdata,
	// Test control
	input wire logic slow,
	input wire logic [31:0] cfg_a,
	input wire logic [31:0] cfg_b
);
	logic [3:0] tick_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tick_q <= 4'h0;
		else
			tick_q <= tick_q + 4'h1;
	end
	// Prompt, or every other cycle when slow
	assign xfer_ready = xfer_valid && (!slow || tick_q[0]);
	// Third word of a four-word task is its configuration; other words keep changing
	assign xfer_rdata = (xfer_valid && !xfer_write && xfer_count[1:0] == 2'h1) ?
		(xfer_count[2] ? cfg_a : cfg_b) : {8{tick_q}};
endmodule
